// File: acnv_control.v
/*
 * Control and result-register logic of a 12-bit successive approximation
 * converter with four external pins and three internal sources.
 * Assumes an Avalon-MM master on core_clk_i and an analog comparator whose
 * output arrives asynchronously and is synchronised here.
 */
// Decided for this implementation: the Avalon-MM register port and the address map.
//
// Contract
// R1: Produce 12-bit result for selected source
// R2: Four external pins plus three internal sources
// R3: Channel field picks the external pin
// R4: Source field picks internal or external
// R5: Alignment bit sets result byte placement
// R6: Unused result bit positions read zero
// R7: Result registers are read only
// R8: Disabled converter leaves results unchanged
// R9: Two 8-bit control registers exist
// R10: Control register bit layouts as documented
// R11: Exactly one signal routed to converter; code routes none while disabled or while the selected pin is not in pin select
// R12: Pin select decides converter input pins
// R13: Selected pin loses its I/O function
// R14: Selected pin loses its pull-up
// R15: Start high then low begins conversion
// R16: Busy set at start, cleared at completion
// R17: Enable powers converter, clear powers down
// R18: Both result bytes update with busy clear
// R19: Settings latch per conversion; alignment immediate; code does not latch reference select, which follows the register
`timescale 1ns/1ps
`default_nettype none
`include "acnv_defs.vh"

module acnv_control #(
  parameter CHANNELS = 4,
  parameter RES_BITS = 12
) (
  // Clock and reset
  input  wire                 core_clk_i,
  input  wire                 rst_i,
  // Avalon-MM slave
  input  wire [4:0]           avs_address_i,
  input  wire                 avs_read_i,
  input  wire                 avs_write_i,
  input  wire [31:0]          avs_writedata_i,
  input  wire [3:0]           avs_byteenable_i,
  output reg  [31:0]          avs_readdata_o,
  output wire                 avs_waitrequest_o,
  // Interrupt
  output wire                 irq_o,
  // Analog front end
  input  wire                 cmp_i,
  output reg                  conv_power_o,
  output reg                  sample_o,
  output reg  [RES_BITS-1:0]  dac_code_o,
  output reg  [CHANNELS-1:0]  analog_input_pins_o,
  output reg                  bandgap_reference_o,
  output reg                  amp_zero_output_o,
  output reg                  amp_one_output_o,
  output reg  [1:0]           reference_select_o,
  // Pin sharing
  output wire [CHANNELS-1:0]  pin_analog_sel_o,
  output wire [CHANNELS-1:0]  pin_gpio_release_o,
  output wire [CHANNELS-1:0]  pin_pullup_release_o
);

  localparam ST_IDLE   = 2'h0;
  localparam ST_SAMPLE = 2'h1;
  localparam ST_CONV   = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0]           conv_control_primary_reg;
  reg [7:0]           conv_control_secondary_reg;
  reg [RES_BITS-1:0]  result_reg;
  reg [CHANNELS-1:0]  pin_sel_reg;
  reg [1:0]           irq_stat_reg;
  reg [1:0]           irq_mask_reg;
  reg                 rd_ack_reg;
  reg [1:0]           state_reg;
  reg [RES_BITS-1:0]  sar_reg;
  reg [RES_BITS-1:0]  bit_reg;
  reg [3:0]           tick_reg;
  reg [3:0]           tick_div_reg;
  reg [2:0]           clk_sel_lat_reg;
  reg [2:0]           src_lat_reg;
  reg [3:0]           chan_lat_reg;
  reg                 cmp_meta_reg;
  reg                 cmp_sync_reg;

  wire       conv_enable           = conv_control_primary_reg[`ACNV_PRI_ENABLE];
  wire       result_align_select   = conv_control_primary_reg[`ACNV_PRI_ALIGN];
  wire       conv_busy_flag        = (state_reg != ST_IDLE);
  wire       wr_pri  = avs_write_i && avs_byteenable_i[0] &&
                       (avs_address_i == {1'b0, `ACNV_OFF_CTRL_PRI});
  wire [7:0] wdat    = avs_writedata_i[7:0];
  wire       start_was = conv_control_primary_reg[`ACNV_PRI_START];
  // Falling edge of the start bit written by software
  wire       start_fall = wr_pri && start_was && !wdat[`ACNV_PRI_START];   // see R15
  wire       go       = start_fall && conv_enable && !conv_busy_flag;
  wire       conv_tick = (tick_div_reg == 4'h0);
  // An aborted run must not flag completion
  wire       done     = (state_reg == ST_CONV) && conv_enable && conv_tick && bit_reg[0];

  // Writes take one cycle; reads wait one cycle for registered data
  assign avs_waitrequest_o = avs_read_i && !rd_ack_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // Pins selected as converter inputs give up digital functions
  assign pin_analog_sel_o     = pin_sel_reg;   // see R12
  assign pin_gpio_release_o   = pin_sel_reg;   // see R13
  assign pin_pullup_release_o = pin_sel_reg;   // see R14

  //////////////////////////////////////////////////////////////////////////
  // Converter clock divider: divide by 2^select for select 0 to 4; select 5 to 7 also divide by 16
  function [3:0] acnv_div_load;
    input [2:0] sel;
    begin
      acnv_div_load = (4'h1 << sel[1:0]) - 4'h1;
      if (sel[2]) begin
        acnv_div_load = 4'hF;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      cmp_meta_reg <= 1'b0;
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= cmp_i;
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      conv_control_primary_reg   <= `ACNV_RST_CTRL_PRI;
      conv_control_secondary_reg <= `ACNV_RST_CTRL_SEC;
      pin_sel_reg                <= `ACNV_RST_PIN_SEL;
      irq_mask_reg               <= 2'h0;
    end else if (avs_write_i) begin
      if (wr_pri) begin
        // Busy bit is read only and never stored
        conv_control_primary_reg <= wdat & 8'hBF;   // see R9 R10 R16
      end else if (avs_address_i == {1'b0, `ACNV_OFF_CTRL_SEC} && avs_byteenable_i[0]) begin
        conv_control_secondary_reg <= wdat;   // see R9 R10
      end else if (avs_address_i == `ACNV_OFF_PIN_SEL && avs_byteenable_i[0]) begin
        pin_sel_reg <= wdat[CHANNELS-1:0];
      end else if (avs_address_i == `ACNV_OFF_IRQ_MASK && avs_byteenable_i[0]) begin
        irq_mask_reg <= wdat[1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over write-one-to-clear
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 2'h0;
    end else begin
      if (avs_write_i && avs_address_i == `ACNV_OFF_IRQ_STAT && avs_byteenable_i[0]) begin
        irq_stat_reg[`ACNV_IRQ_DONE]  <= (irq_stat_reg[`ACNV_IRQ_DONE] &&
                                          !wdat[`ACNV_IRQ_DONE]) || done;
        irq_stat_reg[`ACNV_IRQ_START] <= (irq_stat_reg[`ACNV_IRQ_START] &&
                                          !wdat[`ACNV_IRQ_START]) || go;
      end else begin
        irq_stat_reg[`ACNV_IRQ_DONE]  <= irq_stat_reg[`ACNV_IRQ_DONE] || done;
        irq_stat_reg[`ACNV_IRQ_START] <= irq_stat_reg[`ACNV_IRQ_START] || go;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg       <= ST_IDLE;
      sar_reg         <= {RES_BITS{1'b0}};
      bit_reg         <= {RES_BITS{1'b0}};
      tick_reg        <= 4'h0;
      tick_div_reg    <= 4'h0;
      clk_sel_lat_reg <= 3'h0;
      src_lat_reg     <= 3'h0;
      chan_lat_reg    <= 4'h0;
      result_reg      <= `ACNV_RST_RESULT;
    end else begin
      tick_div_reg <= conv_tick ? acnv_div_load(clk_sel_lat_reg) : tick_div_reg - 4'h1;
      case (state_reg)
        ST_IDLE: begin
          if (go) begin   // see R15 R16
            // Settings are captured here so later writes hit the next run
            clk_sel_lat_reg <= conv_control_secondary_reg[`ACNV_SEC_CLK_HI:`ACNV_SEC_CLK_LO]; // see R19
            src_lat_reg     <= conv_control_secondary_reg[`ACNV_SEC_SRC_HI:`ACNV_SEC_SRC_LO]; // see R19
            chan_lat_reg    <= conv_control_primary_reg[`ACNV_PRI_CHAN_HI:`ACNV_PRI_CHAN_LO]; // see R19
            tick_reg        <= `ACNV_SAMPLE_TICKS;
            tick_div_reg    <= acnv_div_load(conv_control_secondary_reg[2:0]);
            state_reg       <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: begin
          if (conv_tick) begin
            if (tick_reg == 4'h1) begin
              bit_reg   <= {1'b1, {(RES_BITS-1){1'b0}}};
              sar_reg   <= {1'b1, {(RES_BITS-1){1'b0}}};
              state_reg <= ST_CONV;
            end else begin
              tick_reg <= tick_reg - 4'h1;
            end
          end
        end
        ST_CONV: begin
          if (!conv_enable) begin
            // Power-down aborts; result keeps its old value
            state_reg <= ST_IDLE;   // see R8 R17
          end else if (conv_tick) begin
            // Keep the trial bit if the input is above the DAC level
            sar_reg <= (cmp_sync_reg ? sar_reg : (sar_reg & ~bit_reg)) | (bit_reg >> 1); // see R1
            bit_reg <= bit_reg >> 1;
            if (bit_reg[0]) begin
              // Whole word lands with busy clearing
              result_reg <= cmp_sync_reg ? sar_reg : (sar_reg & ~bit_reg);   // see R1 R18 R16
              state_reg  <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      if (!conv_enable && state_reg == ST_SAMPLE) begin
        state_reg <= ST_IDLE;   // see R8 R17
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Analog routing: at most one source reaches the converter; none while disabled or while the selected pin is not in pin select
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      conv_power_o        <= 1'b0;
      sample_o            <= 1'b0;
      dac_code_o          <= {RES_BITS{1'b0}};
      analog_input_pins_o <= {CHANNELS{1'b0}};
      bandgap_reference_o <= 1'b0;
      amp_zero_output_o   <= 1'b0;
      amp_one_output_o    <= 1'b0;
      reference_select_o  <= 2'h0;
    end else begin
      conv_power_o        <= conv_enable;   // see R17
      sample_o            <= (state_reg == ST_SAMPLE);
      dac_code_o          <= sar_reg;
      reference_select_o  <= conv_control_secondary_reg[`ACNV_SEC_REF_HI:`ACNV_SEC_REF_LO];
      bandgap_reference_o <= conv_enable && (src_lat_reg == `ACNV_SRC_BANDGAP);   // see R2 R4 R11
      amp_zero_output_o   <= conv_enable && (src_lat_reg == `ACNV_SRC_AMP_ZERO);  // see R2 R4 R11
      amp_one_output_o    <= conv_enable && (src_lat_reg == `ACNV_SRC_AMP_ONE);   // see R2 R4 R11
      analog_input_pins_o <= {CHANNELS{1'b0}};
      if (conv_enable && (src_lat_reg == `ACNV_SRC_EXTERNAL || src_lat_reg > `ACNV_SRC_AMP_ONE)
          && chan_lat_reg < CHANNELS) begin
        analog_input_pins_o[chan_lat_reg[1:0]] <= pin_sel_reg[chan_lat_reg[1:0]]; // see R3 R11 R12
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register reads
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_ack_reg     <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      rd_ack_reg     <= avs_read_i && !rd_ack_reg;
      avs_readdata_o <= 32'h0000_0000;
      if (avs_address_i == {1'b0, `ACNV_OFF_RES_HIGH}) begin
        // Alignment applies at read time; unused bits are zero
        avs_readdata_o[7:0] <= result_align_select ? {4'h0, result_reg[11:8]}
                                                   : result_reg[11:4];   // see R5 R6 R7 R19
      end else if (avs_address_i == {1'b0, `ACNV_OFF_RES_LOW}) begin
        avs_readdata_o[7:0] <= result_align_select ? result_reg[7:0]
                                                   : {result_reg[3:0], 4'h0};   // see R5 R6 R7
      end else if (avs_address_i == {1'b0, `ACNV_OFF_CTRL_PRI}) begin
        avs_readdata_o[7:0] <= {conv_control_primary_reg[7], conv_busy_flag,
                                conv_control_primary_reg[5:0]};   // see R10 R16
      end else if (avs_address_i == {1'b0, `ACNV_OFF_CTRL_SEC}) begin
        avs_readdata_o[7:0] <= conv_control_secondary_reg;
      end else if (avs_address_i == `ACNV_OFF_IRQ_STAT) begin
        avs_readdata_o[1:0] <= irq_stat_reg;
      end else if (avs_address_i == `ACNV_OFF_IRQ_MASK) begin
        avs_readdata_o[1:0] <= irq_mask_reg;
      end else if (avs_address_i == `ACNV_OFF_PIN_SEL) begin
        avs_readdata_o[CHANNELS-1:0] <= pin_sel_reg;
      end
    end
  end

endmodule // acnv_control
`default_nettype wire

// File: acnv_defs.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * converter control block.
 * Assumes inclusion by bare name from the converter control module.
 */
`ifndef ACNV_DEFS_VH
`define ACNV_DEFS_VH

// Byte addresses on the byte-addressed bus (word index times four)
`define ACNV_OFF_RES_HIGH   4'h0
`define ACNV_OFF_RES_LOW    4'h4
`define ACNV_OFF_CTRL_PRI   4'h8
`define ACNV_OFF_CTRL_SEC   4'hC
`define ACNV_OFF_IRQ_STAT   5'h10
`define ACNV_OFF_IRQ_MASK   5'h14
`define ACNV_OFF_PIN_SEL    5'h18

// Primary control fields
`define ACNV_PRI_START      7
`define ACNV_PRI_BUSY       6
`define ACNV_PRI_ENABLE     5
`define ACNV_PRI_ALIGN      4
`define ACNV_PRI_CHAN_HI    3
`define ACNV_PRI_CHAN_LO    0

// Secondary control fields
`define ACNV_SEC_SRC_HI     7
`define ACNV_SEC_SRC_LO     5
`define ACNV_SEC_REF_HI     4
`define ACNV_SEC_REF_LO     3
`define ACNV_SEC_CLK_HI     2
`define ACNV_SEC_CLK_LO     0

// Source codes; codes 4 to 7 also select the external channel
`define ACNV_SRC_EXTERNAL   3'h0
`define ACNV_SRC_BANDGAP    3'h1
`define ACNV_SRC_AMP_ZERO   3'h2
`define ACNV_SRC_AMP_ONE    3'h3

// Interrupt status bits
`define ACNV_IRQ_DONE       0
`define ACNV_IRQ_START      1

// Reset values
`define ACNV_RST_CTRL_PRI   8'h00
`define ACNV_RST_CTRL_SEC   8'h00
`define ACNV_RST_RESULT     12'h000
`define ACNV_RST_PIN_SEL    4'h0

// Successive approximation: one converter clock per result bit plus sampling
`define ACNV_SAMPLE_TICKS   4'h2
`define ACNV_RESULT_BITS    4'hC

`endif

// File: acnv_control_asserts.sv
/* Port-level checker of the converter control block.
   Assumes binding onto acnv_control, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module acnv_control_asserts #(
  parameter CHANNELS = 4,
  parameter RES_BITS = 12
) (
  // Clock and reset
  input wire logic                core_clk_i,
  input wire logic                rst_i,
  // Register bus
  input wire logic [4:0]          avs_address_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire logic [31:0]         avs_writedata_i,
  input wire logic [3:0]          avs_byteenable_i,
  input wire logic [31:0]         avs_readdata_o,
  input wire logic                avs_waitrequest_o,
  // Converter and pins
  input wire logic                conv_power_o,
  input wire logic                sample_o,
  input wire logic [CHANNELS-1:0] analog_input_pins_o,
  input wire logic                bandgap_reference_o,
  input wire logic                amp_zero_output_o,
  input wire logic                amp_one_output_o,
  input wire logic [CHANNELS-1:0] pin_analog_sel_o,
  input wire logic [CHANNELS-1:0] pin_gpio_release_o,
  input wire logic [CHANNELS-1:0] pin_pullup_release_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_read_req;
    $rose(avs_read_i);
  endsequence
  sequence s_read_ans;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  a_read_answer : assert property (s_read_req |-> s_read_ans)
    else $error("Read not answered on its second cycle");
  a_write_nowait : assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("Write was stalled");
  a_upper_zero : assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
    else $error("Read data above byte not zero");
  a_one_source : assert property ($onehot0({analog_input_pins_o, bandgap_reference_o, amp_zero_output_o, amp_one_output_o}))
    else $error("More than one source routed");
  a_pin_gate : assert property ((analog_input_pins_o & ~pin_analog_sel_o) == {CHANNELS{1'b0}})
    else $error("Unselected pin routed to converter");
  a_gpio_release : assert property (pin_gpio_release_o == pin_analog_sel_o)
    else $error("Pin function not released");
  a_pullup_release : assert property (pin_pullup_release_o == pin_analog_sel_o)
    else $error("Pull-up not released");
  a_power_follow : assert property (avs_write_i && avs_address_i == 5'h08 && avs_byteenable_i[0] |-> ##2 conv_power_o == $past(avs_writedata_i[5], 2))
    else $error("Power does not follow enable");
  a_sample_power : assert property (!conv_power_o ##1 !conv_power_o |-> !sample_o)
    else $error("Sampling while powered down");
endmodule // acnv_control_asserts
bind acnv_control acnv_control_asserts #(.CHANNELS(CHANNELS), .RES_BITS(RES_BITS)) u_acnv_control_asserts (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .conv_power_o(conv_power_o), .sample_o(sample_o),
  .analog_input_pins_o(analog_input_pins_o), .bandgap_reference_o(bandgap_reference_o),
  .amp_zero_output_o(amp_zero_output_o), .amp_one_output_o(amp_one_output_o),
  .pin_analog_sel_o(pin_analog_sel_o), .pin_gpio_release_o(pin_gpio_release_o),
  .pin_pullup_release_o(pin_pullup_release_o));
`default_nettype wire

// File: tb_acnv_control.sv
/* Self-checking testbench of the converter control block.
   Assumes acnv_control and its checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s: expected %h seen %h", n, e, g); end end
module tb_acnv_control;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic        cmp_i = 1'b0;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o, irq_o, conv_power_o, sample_o;
  wire         bandgap_reference_o, amp_zero_output_o, amp_one_output_o;
  wire  [11:0] dac_code_o;
  wire  [3:0]  analog_input_pins_o, pin_analog_sel_o, pin_gpio_release_o, pin_pullup_release_o;
  wire  [1:0]  reference_select_o;
  int          mismatches = 0;
  int          samples_checked = 0;
  logic [11:0] target = 12'h000;
  logic [7:0]  rd_v;
  logic [40:0] r;
  // Row: source, channel, align, analog level, high byte, low byte, switches
  logic [40:0] rows [0:5] = '{
    {3'h0, 2'h0, 1'h0, 12'hABC, 8'hAB, 8'hC0, 7'h01},
    {3'h0, 2'h3, 1'h1, 12'h5A3, 8'h05, 8'hA3, 7'h08},
    {3'h1, 2'h1, 1'h0, 12'hFFF, 8'hFF, 8'hF0, 7'h10},
    {3'h2, 2'h0, 1'h1, 12'h001, 8'h00, 8'h01, 7'h20},
    {3'h3, 2'h2, 1'h0, 12'h800, 8'h80, 8'h00, 7'h40},
    {3'h5, 2'h2, 1'h1, 12'h7FF, 8'h07, 8'hFF, 7'h04}};
  acnv_control u_acnv_control (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .cmp_i(cmp_i),
    .conv_power_o(conv_power_o), .sample_o(sample_o), .dac_code_o(dac_code_o),
    .analog_input_pins_o(analog_input_pins_o), .bandgap_reference_o(bandgap_reference_o),
    .amp_zero_output_o(amp_zero_output_o), .amp_one_output_o(amp_one_output_o),
    .reference_select_o(reference_select_o), .pin_analog_sel_o(pin_analog_sel_o),
    .pin_gpio_release_o(pin_gpio_release_o), .pin_pullup_release_o(pin_pullup_release_o));
  always #4 core_clk_i = ~core_clk_i;
  // Comparator: analog level sits just above its code
  always @(posedge core_clk_i) cmp_i <= (target >= dac_code_o);
  ////////////////////////////////////////////////////////////////////////////
  // Request held until the edge that samples waitrequest low
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_write_i <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task automatic end_sim;
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wr(5'h18, 8'h0F);
    `CHK("gpio_release", 4'hF, pin_gpio_release_o)
    wr(5'h14, 8'h01);
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      target <= r[34:23];
      wr(5'h0C, {r[40:38], 2'h2, 3'h3});
      wr(5'h08, {3'h5, r[35], 2'h0, r[37:36]});
      wr(5'h08, {3'h1, r[35], 2'h0, r[37:36]});
      `CHK("ref_sel", 2'h2, reference_select_o)
      rd(5'h08, rd_v);
      `CHK("busy", 1'h1, rd_v[6])
      `CHK("switch", r[6:0], {amp_one_output_o, amp_zero_output_o, bandgap_reference_o, analog_input_pins_o})
      while (rd_v[6]) rd(5'h08, rd_v);
      rd(5'h00, rd_v);
      `CHK("res_high", r[22:15], rd_v)
      rd(5'h04, rd_v);
      `CHK("res_low", r[14:7], rd_v)
      `CHK("irq_on", 1'h1, irq_o)
      wr(5'h14, 8'h00);
      `CHK("irq_masked", 1'h0, irq_o)
      wr(5'h14, 8'h01);
      wr(5'h10, 8'h03);
      `CHK("irq_clear", 1'h0, irq_o)
    end
    wr(5'h00, 8'h55);
    rd(5'h00, rd_v);
    `CHK("ro_high", 8'h07, rd_v)
    wr(5'h08, 8'h00);
    rd(5'h00, rd_v);
    `CHK("off_high", 8'h7F, rd_v)
    rd(5'h04, rd_v);
    `CHK("realign_low", 8'hF0, rd_v)
    wr(5'h08, 8'h80);
    wr(5'h08, 8'h00);
    rd(5'h08, rd_v);
    `CHK("start_off", 8'h00, rd_v)
    rd(5'h1C, rd_v);
    `CHK("unmapped", 8'h00, rd_v)
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(5'h0C, rd_v);
    `CHK("rst_sec", 8'h00, rd_v)
    rd(5'h00, rd_v);
    `CHK("rst_high", 8'h00, rd_v)
    `CHK("rst_pins", 4'h0, pin_analog_sel_o)
    end_sim();
  end
endmodule // tb_acnv_control
`default_nettype wire
